// *** shared/uart_fifo_pkg.sv ***
// Constants and types shared by the serial port FIFO control logic
package uart_fifo_pkg;

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam int TMO_W = 6;
    localparam logic [CNT_W-1:0] FIFO_FULL = 5'h10;
    localparam logic [CNT_W-1:0] TX_HALF = 5'h08;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] OFS_DATA = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_IER = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_IIR_FCR = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_LINE = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_MODEM = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_LSR = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_DMA_CFG = 3'h6;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_AUX = 2;
    localparam int MCR_OUT2 = 3;
    localparam int MCR_LOOP = 4;
    localparam int IER_RX = 0;
    localparam int IER_TX = 1;
    localparam int IER_LS = 2;
    localparam int FCR_EN = 0;
    localparam int FCR_RX_RST = 1;
    localparam int FCR_TX_RST = 2;
    localparam int FCR_TRIG_LO = 6;
    localparam int LINE_STB = 2;
    localparam int LINE_PEN = 3;
    localparam int DMA_EN = 0;

    // ----------------------------------------
    // Reset values and write masks
    // ----------------------------------------
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] MCR_MASK = 8'h1f;
    localparam logic [7:0] IER_RST = 8'h00;
    localparam logic [7:0] IER_MASK = 8'h0f;
    localparam logic [7:0] LINE_RST = 8'h00;
    localparam logic [7:0] DMA_RST = 8'h00;
    localparam logic [1:0] TRIG_RST = 2'h0;

    // ----------------------------------------
    // Identification codes
    // ----------------------------------------
    localparam logic [7:0] IIR_FIFO_BITS = 8'hc0;
    localparam logic [7:0] IIR_NONE = 8'h01;
    localparam logic [7:0] IIR_LS = 8'h06;
    localparam logic [7:0] IIR_RDA = 8'h04;
    localparam logic [7:0] IIR_TMO = 8'h0c;
    localparam logic [7:0] IIR_THR = 8'h02;

    // ----------------------------------------
    // Trigger levels and character timing
    // ----------------------------------------
    localparam logic [CNT_W-1:0] TRIG_1 = 5'h01;
    localparam logic [CNT_W-1:0] TRIG_4 = 5'h04;
    localparam logic [CNT_W-1:0] TRIG_8 = 5'h08;
    localparam logic [CNT_W-1:0] TRIG_14 = 5'h0e;
    localparam logic [3:0] START_BITS = 4'h1;
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam logic [3:0] STOP_BITS = 4'h1;
    localparam int TMO_CHARS_LOG2 = 2;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic brk;
        logic frame_err;
        logic parity_err;
        logic [7:0] data;
    } rx_entry_t;

    localparam int RX_ENTRY_W = 11;

    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_LS,
        SRC_RDA,
        SRC_TMO,
        SRC_THR
    } irq_src_t;

endpackage

// *** hw/fifo_mem.sv ***
// Small FIFO storage array with a registered read port
`timescale 1ns/100ps
module fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clock,              // System clock
    input wire logic we,                 // Write strobe
    input wire logic [AW-1:0] waddr,     // Write address
    input wire logic [WIDTH-1:0] wdata,  // Write data
    input wire logic [AW-1:0] raddr,     // Read address
    output logic [WIDTH-1:0] rdata       // Registered read data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rdata;

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Bypass so a word written into an empty FIFO is the head at once
    always_comb begin
        if (we && (waddr == raddr)) begin
            next_rdata = wdata;
        end else begin
            next_rdata = mem[raddr];
        end
    end

    // Storage has no reset; only the control state needs one
    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= next_rdata;
    end
endmodule // fifo_mem

// *** hw/uart_fifo_ctrl.sv ***
// FIFO control, interrupt identification and DMA requests of a serial port
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps

// How it works
// - Request-to-send pin low while modem bit 1 set and loopback off.
// - Terminal-ready pin low while modem bit 0 set and loopback off.
// - Modem bit 2 acts only in loopback.
// - Receive-data interrupt while FIFO level at or above trigger.
// - Line status outranks receive data; codes C6 and C4.
// - FIFO-mode line status for an errored head character or an overrun.
// - Data ready set on arrival, cleared when FIFO empty.
// - Timeout: data, four idle character times, no read, trigger above one.
// - A FIFO read clears the timeout; arrivals and reads restart it.
// - Transmit request on becoming half empty; data write or ident read clears.
// - FIFOs on with enables zero is polled mode per direction.
// - Status: data, head errors, transmit need, idle, any error.
// - Separate DMA requests, FIFO mode only.
// - Transmit DMA request while half empty and DMA enabled.
// - Receive DMA request at trigger with no errors; never at trigger one.
// - An errored entry drops the receive DMA request at once.
// - Receive DMA request returns once errors are read out.
// - Character time: start, data, optional parity, stop bits.
module uart_fifo_ctrl
    import uart_fifo_pkg::*;
(
    input wire logic clock,                  // System clock, 20 MHz
    input wire logic rst,                    // Asynchronous reset, active high
    input wire logic [ADDR_W-1:0] reg_addr,  // Register address
    input wire logic [7:0] reg_wdata,        // Register write data
    input wire logic reg_wr,                 // Write strobe
    input wire logic reg_rd,                 // Read strobe
    output logic [7:0] reg_rdata,            // Read data, cycle after strobe
    input wire logic rx_push,                // Receive shift register done
    input wire rx_entry_t rx_char,           // Received character and errors
    input wire logic rx_bit_tick,            // One pulse per receive bit time
    input wire logic tx_pop,                 // Transmit shift register takes head
    input wire logic tx_shift_empty,         // Transmit shift register idle
    output logic [7:0] tx_data,              // Head of transmit FIFO
    output logic tx_valid,                   // Transmit FIFO not empty
    output logic [7:0] line_ctrl,            // Frame format for the shifters
    output logic rts_n,                      // Request to send, active low
    output logic dtr_n,                      // Terminal ready, active low
    output logic out2_n,                     // Interrupt gate pin, active low
    output logic loop_mode,                  // Loopback test mode active
    output logic loop_ri,                    // Aux bit looped to ring input
    output logic uart_irq,                   // Interrupt pending, active high
    output logic tx_dma_req,                 // Transmit DMA request
    output logic rx_dma_req                  // Receive DMA request
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] modem_line_control, next_modem_line_control;
    logic [7:0] interrupt_enable_reg, next_interrupt_enable_reg;
    logic [7:0] line_reg, next_line_reg;
    logic [7:0] dma_cfg, next_dma_cfg;
    logic fifo_enable_bit, next_fifo_enable_bit;
    logic [1:0] trig_sel, next_trig_sel;
    logic [PTR_W-1:0] rx_wr_ptr, next_rx_wr_ptr, rx_rd_ptr, next_rx_rd_ptr;
    logic [PTR_W-1:0] tx_wr_ptr, next_tx_wr_ptr, tx_rd_ptr, next_tx_rd_ptr;
    logic [CNT_W-1:0] rx_count, next_rx_count, tx_count, next_tx_count;
    logic [CNT_W-1:0] err_count, next_err_count;
    logic overrun, next_overrun;
    logic lsr_seen, next_lsr_seen;
    logic [TMO_W-1:0] tmo_cnt, next_tmo_cnt;
    logic tmo_flag, next_tmo_flag;
    logic thr_flag, next_thr_flag;
    logic tx_need_q, next_tx_need_q;
    logic [7:0] next_reg_rdata;
    logic next_tx_valid, next_rts_n, next_dtr_n, next_out2_n;
    logic next_loop_mode, next_loop_ri, next_uart_irq;
    logic next_tx_dma_req, next_rx_dma_req;

    // Combinational helpers
    rx_entry_t rx_head;
    logic [7:0] tx_head;
    logic rx_take, rx_pop, rx_full, tx_take, tx_drop, tx_full;
    logic rx_clr, tx_clr, tx_need, head_vis, head_err, rda_cond, ls_cond;
    logic rx_char_ready;
    logic [CNT_W-1:0] trig_level;
    logic [3:0] char_bits;
    logic [TMO_W-1:0] tmo_limit;
    irq_src_t irq_src;
    logic [7:0] iir_val, lsr_val;

    // ----------------------------------------
    // FIFO storage
    // ----------------------------------------
    fifo_mem #(.WIDTH(RX_ENTRY_W), .DEPTH(FIFO_DEPTH), .AW(PTR_W)) rx_mem (
        .clock(clock),
        .we(rx_take),
        .waddr(rx_wr_ptr),
        .wdata(rx_char),
        .raddr(next_rx_rd_ptr),
        .rdata(rx_head)
    );

    fifo_mem #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(PTR_W)) tx_mem (
        .clock(clock),
        .we(tx_take),
        .waddr(tx_wr_ptr),
        .wdata(reg_wdata),
        .raddr(next_tx_rd_ptr),
        .rdata(tx_head)
    );

    assign tx_data = tx_head;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        // Register writes
        next_modem_line_control = modem_line_control;
        next_interrupt_enable_reg = interrupt_enable_reg;
        next_line_reg = line_reg;
        next_dma_cfg = dma_cfg;
        next_fifo_enable_bit = fifo_enable_bit;
        next_trig_sel = trig_sel;
        rx_clr = 1'b0;
        tx_clr = 1'b0;
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_IER: next_interrupt_enable_reg = reg_wdata & IER_MASK;
                OFS_IIR_FCR: begin
                    next_fifo_enable_bit = reg_wdata[FCR_EN];
                    next_trig_sel = reg_wdata[FCR_TRIG_LO +: 2];
                    rx_clr = reg_wdata[FCR_RX_RST];
                    tx_clr = reg_wdata[FCR_TX_RST];
                end
                OFS_LINE: next_line_reg = reg_wdata;
                OFS_MODEM: next_modem_line_control = reg_wdata & MCR_MASK;
                OFS_DMA_CFG: next_dma_cfg = {7'h00, reg_wdata[DMA_EN]};
                default: next_line_reg = line_reg;
            endcase
        end

        // Trigger level decode
        unique case (trig_sel)
            2'h0: trig_level = TRIG_1;
            2'h1: trig_level = TRIG_4;
            2'h2: trig_level = TRIG_8;
            2'h3: trig_level = TRIG_14;
        endcase

        // Receive FIFO; outside FIFO mode it holds one character only
        rx_full = fifo_enable_bit ? (rx_count == FIFO_FULL) : (rx_count != 5'h00);
        rx_take = rx_push && !rx_full && !rx_clr;
        rx_pop = reg_rd && (reg_addr == OFS_DATA) && (rx_count != 5'h00);
        head_err = rx_head.brk | rx_head.frame_err | rx_head.parity_err;
        next_rx_wr_ptr = rx_take ? rx_wr_ptr + 4'h1 : rx_wr_ptr;
        next_rx_rd_ptr = rx_pop ? rx_rd_ptr + 4'h1 : rx_rd_ptr;
        next_rx_count = rx_count + {4'h0, rx_take} - {4'h0, rx_pop};
        // Entries with errors are counted so clearance is exact
        next_err_count = err_count
            + {4'h0, rx_take & (rx_char.brk | rx_char.frame_err | rx_char.parity_err)}
            - {4'h0, rx_pop & head_err};
        if (rx_clr) begin
            next_rx_wr_ptr = 4'h0;
            next_rx_rd_ptr = 4'h0;
            next_rx_count = 5'h00;
            next_err_count = 5'h00;
        end
        rx_char_ready = (rx_count != 5'h00);

        // Transmit FIFO; outside FIFO mode it is a single holding register
        tx_full = fifo_enable_bit ? (tx_count == FIFO_FULL) : (tx_count != 5'h00);
        tx_take = reg_wr && (reg_addr == OFS_DATA) && !tx_full && !tx_clr;
        tx_drop = tx_pop && (tx_count != 5'h00);
        next_tx_wr_ptr = tx_take ? tx_wr_ptr + 4'h1 : tx_wr_ptr;
        next_tx_rd_ptr = tx_drop ? tx_rd_ptr + 4'h1 : tx_rd_ptr;
        next_tx_count = tx_count + {4'h0, tx_take} - {4'h0, tx_drop};
        if (tx_clr) begin
            next_tx_wr_ptr = 4'h0;
            next_tx_rd_ptr = 4'h0;
            next_tx_count = 5'h00;
        end
        tx_need = fifo_enable_bit ? (tx_count <= TX_HALF) : (tx_count == 5'h00);
        next_tx_need_q = tx_need;

        // Overrun and head error visibility; status read hides head errors
        next_overrun = overrun;
        if (reg_rd && (reg_addr == OFS_LSR)) begin
            next_overrun = 1'b0;
        end
        if (rx_push && rx_full) begin
            next_overrun = 1'b1;
        end
        next_lsr_seen = lsr_seen;
        if (reg_rd && (reg_addr == OFS_LSR)) begin
            next_lsr_seen = 1'b1;
        end
        if (rx_pop || rx_clr) begin
            next_lsr_seen = 1'b0;
        end
        head_vis = rx_char_ready && !lsr_seen && head_err;
        ls_cond = overrun | head_vis;

        // Character time from the frame format; half stop bit rounds up
        char_bits = START_BITS + MIN_DATA_BITS + {2'h0, line_reg[1:0]}
            + {3'h0, line_reg[LINE_PEN]} + STOP_BITS + {3'h0, line_reg[LINE_STB]};
        tmo_limit = {char_bits, 2'h0};
        // Timer counts bit ticks and saturates at four character times
        next_tmo_cnt = tmo_cnt;
        if (rx_take || rx_pop || rx_clr) begin
            next_tmo_cnt = 6'h00;
        end else if (rx_bit_tick && (tmo_cnt != tmo_limit)) begin
            next_tmo_cnt = tmo_cnt + 6'h01;
        end
        next_tmo_flag = tmo_flag;
        if (rx_pop || rx_clr) begin
            next_tmo_flag = 1'b0;
        end
        if (fifo_enable_bit && interrupt_enable_reg[IER_RX] && rx_char_ready
            && (trig_level > TRIG_1) && (tmo_cnt == tmo_limit)
            && !rx_take && !rx_pop && !rx_clr) begin
            next_tmo_flag = 1'b1;
        end

        // Receive data available follows the level, not an edge
        rda_cond = interrupt_enable_reg[IER_RX]
            && (fifo_enable_bit ? (rx_count >= trig_level) : rx_char_ready);

        // Interrupt source priority
        if (interrupt_enable_reg[IER_LS] && ls_cond) begin
            irq_src = SRC_LS;
        end else if (rda_cond) begin
            irq_src = SRC_RDA;
        end else if (tmo_flag) begin
            irq_src = SRC_TMO;
        end else if (interrupt_enable_reg[IER_TX] && thr_flag) begin
            irq_src = SRC_THR;
        end else begin
            irq_src = SRC_NONE;
        end
        unique case (irq_src)
            SRC_LS: iir_val = IIR_LS;
            SRC_RDA: iir_val = IIR_RDA;
            SRC_TMO: iir_val = IIR_TMO;
            SRC_THR: iir_val = IIR_THR;
            SRC_NONE: iir_val = IIR_NONE;
        endcase
        iir_val = iir_val | (fifo_enable_bit ? IIR_FIFO_BITS : 8'h00);
        next_uart_irq = (irq_src != SRC_NONE);

        // Transmit request flag: a new half-empty event beats the clear
        next_thr_flag = thr_flag;
        if (tx_take || (reg_rd && (reg_addr == OFS_IIR_FCR) && (irq_src == SRC_THR))) begin
            next_thr_flag = 1'b0;
        end
        if (tx_need && (!tx_need_q || tx_clr)) begin
            next_thr_flag = 1'b1;
        end

        // Line status as seen by polling software
        lsr_val = {fifo_enable_bit && (err_count != 5'h00),
                   (tx_count == 5'h00) && tx_shift_empty,
                   tx_need,
                   head_vis && rx_head.brk,
                   head_vis && rx_head.frame_err,
                   head_vis && rx_head.parity_err,
                   overrun,
                   rx_char_ready};

        // Read data, presented in the cycle after the strobe
        next_reg_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_DATA: next_reg_rdata = rx_head.data;
                OFS_IER: next_reg_rdata = interrupt_enable_reg;
                OFS_IIR_FCR: next_reg_rdata = iir_val;
                OFS_LINE: next_reg_rdata = line_reg;
                OFS_MODEM: next_reg_rdata = modem_line_control;
                OFS_LSR: next_reg_rdata = lsr_val;
                OFS_DMA_CFG: next_reg_rdata = dma_cfg;
                default: next_reg_rdata = 8'h00;
            endcase
        end

        // Modem pins; loopback parks them inactive and loops the aux bit
        next_loop_mode = modem_line_control[MCR_LOOP];
        next_rts_n = next_loop_mode | ~modem_line_control[MCR_RTS];
        next_dtr_n = next_loop_mode | ~modem_line_control[MCR_DTR];
        next_out2_n = next_loop_mode | ~modem_line_control[MCR_OUT2];
        next_loop_ri = next_loop_mode & modem_line_control[MCR_AUX];

        // DMA requests exist in FIFO mode only
        next_tx_dma_req = fifo_enable_bit && dma_cfg[DMA_EN] && tx_need;
        next_rx_dma_req = fifo_enable_bit && dma_cfg[DMA_EN]
            && (trig_level != TRIG_1) && (rx_count >= trig_level)
            && (err_count == 5'h00);
        next_tx_valid = (next_tx_count != 5'h00);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Every output is taken from a flip-flop so the pins never glitch
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            modem_line_control <= MCR_RST;
            interrupt_enable_reg <= IER_RST;
            line_reg <= LINE_RST;
            dma_cfg <= DMA_RST;
            fifo_enable_bit <= 1'b0;
            trig_sel <= TRIG_RST;
            rx_wr_ptr <= 4'h0;
            rx_rd_ptr <= 4'h0;
            tx_wr_ptr <= 4'h0;
            tx_rd_ptr <= 4'h0;
            rx_count <= 5'h00;
            tx_count <= 5'h00;
            err_count <= 5'h00;
            overrun <= 1'b0;
            lsr_seen <= 1'b0;
            tmo_cnt <= 6'h00;
            tmo_flag <= 1'b0;
            thr_flag <= 1'b0;
            tx_need_q <= 1'b0;
            reg_rdata <= 8'h00;
            tx_valid <= 1'b0;
            line_ctrl <= LINE_RST;
            rts_n <= 1'b1;
            dtr_n <= 1'b1;
            out2_n <= 1'b1;
            loop_mode <= 1'b0;
            loop_ri <= 1'b0;
            uart_irq <= 1'b0;
            tx_dma_req <= 1'b0;
            rx_dma_req <= 1'b0;
        end else begin
            modem_line_control <= next_modem_line_control;
            interrupt_enable_reg <= next_interrupt_enable_reg;
            line_reg <= next_line_reg;
            dma_cfg <= next_dma_cfg;
            fifo_enable_bit <= next_fifo_enable_bit;
            trig_sel <= next_trig_sel;
            rx_wr_ptr <= next_rx_wr_ptr;
            rx_rd_ptr <= next_rx_rd_ptr;
            tx_wr_ptr <= next_tx_wr_ptr;
            tx_rd_ptr <= next_tx_rd_ptr;
            rx_count <= next_rx_count;
            tx_count <= next_tx_count;
            err_count <= next_err_count;
            overrun <= next_overrun;
            lsr_seen <= next_lsr_seen;
            tmo_cnt <= next_tmo_cnt;
            tmo_flag <= next_tmo_flag;
            thr_flag <= next_thr_flag;
            tx_need_q <= next_tx_need_q;
            reg_rdata <= next_reg_rdata;
            tx_valid <= next_tx_valid;
            line_ctrl <= next_line_reg;
            rts_n <= next_rts_n;
            dtr_n <= next_dtr_n;
            out2_n <= next_out2_n;
            loop_mode <= next_loop_mode;
            loop_ri <= next_loop_ri;
            uart_irq <= next_uart_irq;
            tx_dma_req <= next_tx_dma_req;
            rx_dma_req <= next_rx_dma_req;
        end
    end
endmodule // uart_fifo_ctrl

// *** bench/uart_fifo_ctrl_monitor.sv ***
// Port-level checker for the serial port FIFO control block
`timescale 1ns/100ps
module uart_fifo_ctrl_monitor
    import uart_fifo_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic rst, // Reset
    input wire logic [ADDR_W-1:0] reg_addr, // Address
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic rx_push, // Char pushed
    input wire rx_entry_t rx_char, // Char
    input wire logic tx_valid, // Tx queued
    input wire logic rts_n, // Rts pin
    input wire logic dtr_n, // Dtr pin
    input wire logic out2_n, // Out2 pin
    input wire logic loop_mode, // Loopback
    input wire logic loop_ri, // Aux loop
    input wire logic rx_dma_req // Rx dma
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ----
    // Pins settle two edges after a lone modem write
    // ----
    sequence s_mcr;
        reg_wr && reg_addr == OFS_MODEM && !reg_wdata[MCR_LOOP] ##1 !reg_wr;
    endsequence
    a_rts_follow: assert property (s_mcr |=> rts_n == !$past(reg_wdata[MCR_RTS], 2))
        else $error("rts pin wrong");
    a_dtr_follow: assert property (s_mcr |=> dtr_n == !$past(reg_wdata[MCR_DTR], 2))
        else $error("dtr pin wrong");
    a_loop_pins: assert property (loop_mode && $past(loop_mode) |-> rts_n && dtr_n && out2_n)
        else $error("pins driven in loopback");
    a_aux_loop_only: assert property (loop_ri |-> loop_mode)
        else $error("aux bit leaks out");
    // Errors are recognised by the flags travelling with the character
    a_rx_dma_drop: assert property (rx_push && !reg_wr && (rx_char.parity_err
        || rx_char.frame_err || rx_char.brk) |=> ##1 !rx_dma_req)
        else $error("rx dma kept on error");
    a_ready_after_push: assert property (rx_push && !reg_wr ##1
        reg_rd && reg_addr == OFS_LSR |=> reg_rdata[0])
        else $error("data ready missing");
    a_tx_not_idle: assert property (reg_rd && reg_addr == OFS_LSR && tx_valid
        |=> !reg_rdata[6])
        else $error("idle with data queued");
    a_ident_code: assert property (reg_rd && reg_addr == OFS_IIR_FCR
        |=> reg_rdata[3:0] inside {4'h1, 4'h2, 4'h4, 4'h6, 4'hc})
        else $error("bad ident code");
    c_rx_dma: cover property (rx_push ##[1:3] rx_dma_req);
    c_loop: cover property (loop_ri);
    c_err_push: cover property (rx_push && rx_char.parity_err);
endmodule // uart_fifo_ctrl_monitor

// *** bench/line_side_model.sv ***
// Line-side model: receive bit ticks and a slow transmit shifter
`timescale 1ns/100ps
module line_side_model (
    input wire logic clock, // Clock
    input wire logic rst, // Reset
    input wire logic drain, // Let the shifter take bytes
    input wire logic tx_valid, // Byte waiting
    output logic rx_bit_tick, // Bit time pulse
    output logic tx_pop, // Take head byte
    output logic tx_shift_empty // Shifter idle
);
    logic [3:0] busy;
    logic [1:0] div;
    // Fast bit ticks keep timeouts short
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div <= 2'h0;
            busy <= 4'h0;
            tx_pop <= 1'b0;
            rx_bit_tick <= 1'b0;
        end else begin
            div <= div + 2'h1;
            rx_bit_tick <= (div == 2'h3);
            tx_pop <= drain && tx_valid && busy == 4'h0 && !tx_pop;
            busy <= tx_pop ? 4'h9 : (busy != 4'h0 ? busy - 4'h1 : busy);
        end
    end
    assign tx_shift_empty = (busy == 4'h0) && !tx_pop;
endmodule // line_side_model

// *** bench/tb_uart_fifo_ctrl.sv ***
// Self-checking bench for the serial port FIFO control block
`timescale 1ns/100ps
module tb_uart_fifo_ctrl;
    import uart_fifo_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rx_push = 1'b0, drain = 1'b0;
    rx_entry_t rx_char = '0;
    logic [7:0] reg_rdata, tx_data, line_ctrl, m;
    logic rx_bit_tick, tx_pop, tx_shift_empty, tx_valid, rts_n, dtr_n, out2_n;
    logic loop_mode, loop_ri, uart_irq, tx_dma_req, rx_dma_req;
    logic [7:0] mcr_vals [6] = '{8'h01, 8'h02, 8'h0f, 8'h17, 8'h04, 8'h00};
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    always #25 clock = ~clock;
    uart_fifo_ctrl u_uart_fifo_ctrl (.*);
    line_side_model u_line_side_model (.*);
    // ----
    // Bus tasks; a free cycle between strobes
    // ----
    task check(input string what, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check(what, reg_rdata, exp);
    endtask
    task push(input logic [10:0] e);
        @(posedge clock);
        rx_char <= e;
        rx_push <= 1'b1;
        @(posedge clock);
        rx_push <= 1'b0;
    endtask
    // Let registered outputs settle
    task idle();
        repeat (3) @(posedge clock);
        #1;
    endtask
    task summarize();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        idle();
        check("rts_n", rts_n, 1);
        rd(3'h7, 8'h00, "unmap");
        wr(OFS_DMA_CFG, 8'h01);
        idle();
        check("txdma", tx_dma_req, 0);
        foreach (mcr_vals[i]) begin
            m = mcr_vals[i];
            wr(OFS_MODEM, m);
            idle();
            check("rts_n", rts_n, !(m[1] & !m[4]));
            check("dtr_n", dtr_n, !(m[0] & !m[4]));
            check("out2_n", out2_n, !(m[3] & !m[4]));
            check("ri", loop_ri, m[2] & m[4]);
            rd(OFS_MODEM, m, "mcr");
        end
        wr(OFS_IIR_FCR, 8'h41);
        wr(OFS_IER, 8'h01);
        check("txdma", tx_dma_req, 1);
        repeat (3) push(11'h011);
        idle();
        check("irq", uart_irq, 0);
        push(11'h011);
        idle();
        check("irq", uart_irq, 1);
        check("rxdma", rx_dma_req, 1);
        rd(OFS_IIR_FCR, 8'hc4, "iir");
        rd(OFS_DATA, 8'h11, "rbr");
        idle();
        check("irq", uart_irq, 0);
        push(11'h122);
        idle();
        check("rxdma", rx_dma_req, 0);
        wr(OFS_IER, 8'h05);
        rd(OFS_IIR_FCR, 8'hc4, "iir");
        repeat (3) rd(OFS_DATA, 8'h11, "rbr");
        idle();
        rd(OFS_IIR_FCR, 8'hc6, "iir");
        rd(OFS_LSR, 8'he5, "lsr");
        rd(OFS_DATA, 8'h22, "rbr");
        rd(OFS_LSR, 8'h60, "lsr");
        wr(OFS_LINE, 8'h07);
        repeat (4) push(11'h033);
        idle();
        check("lcr", line_ctrl, 8'h07);
        check("rxdma", rx_dma_req, 1);
        repeat (3) rd(OFS_DATA, 8'h33, "rbr");
        idle();
        check("irq", uart_irq, 0);
        n = 0;
        while (uart_irq !== 1'b1 && n < 400) begin
            @(posedge clock);
            n++;
        end
        check("tmo", n > 160 && n < 200, 1);
        rd(OFS_IIR_FCR, 8'hcc, "iir");
        rd(OFS_DATA, 8'h33, "rbr");
        idle();
        check("irq", uart_irq, 0);
        repeat (9) wr(OFS_DATA, 8'h40);
        idle();
        check("txdma", tx_dma_req, 0);
        check("txd", tx_data, 8'h40);
        rd(OFS_LSR, 8'h00, "lsr");
        drain <= 1'b1;
        n = 0;
        while (!(tx_shift_empty === 1'b1 && tx_valid === 1'b0) && n < 300) begin
            @(posedge clock);
            n++;
        end
        idle();
        check("txdma", tx_dma_req, 1);
        rd(OFS_LSR, 8'h60, "lsr");
        wr(OFS_IER, 8'h02);
        rd(OFS_IIR_FCR, 8'hc2, "iir");
        rd(OFS_IIR_FCR, 8'hc1, "iir");
        summarize();
    end
endmodule // tb_uart_fifo_ctrl
bind uart_fifo_ctrl uart_fifo_ctrl_monitor u_uart_fifo_ctrl_monitor (.*);
